// ===== sas_regs.vh
`ifndef SAS_REGS_VH
`define SAS_REGS_VH

// register byte addresses on the plain register port
`define SAS_ADDR_RESULT     8'h1E
`define SAS_ADDR_CONTROL    8'h1F
`define SAS_ADDR_PINCFG     8'h9F

// reset values
`define SAS_CTL_RESET       8'h00
`define SAS_PINCFG_RESET    3'h0

// control register field positions
`define SAS_CTL_PWR         0
`define SAS_CTL_GO          2
`define SAS_CTL_CHAN_LO     3
`define SAS_CTL_CHAN_HI     5
`define SAS_CTL_CLK_LO      6
`define SAS_CTL_CLK_HI      7

// conversion clock select codes
`define SAS_CLK_DIV2        2'h0
`define SAS_CLK_DIV8        2'h1
`define SAS_CLK_DIV32       2'h2
`define SAS_CLK_RC          2'h3

// half bit-period lengths in reference clock cycles
`define SAS_HALF_DIV2       5'h01
`define SAS_HALF_DIV8       5'h04
`define SAS_HALF_DIV32      5'h10

// a conversion lasts 9.5 bit periods, counted in half periods
`define SAS_CONV_HALVES     5'h13
`define SAS_LAST_DECIDE     5'h10
`define SAS_SAR_START       8'h80

// capture/compare special-event mode code
`define SAS_CCP_SPECIAL     4'hB

// timing figures, reference clock 100 MHz
`define SAS_CLK_PERIOD_NS   10
`define SAS_TAD_MIN_NS      1600
`define SAS_TAD_MIN_CYC     ((`SAS_TAD_MIN_NS + `SAS_CLK_PERIOD_NS - 1) / `SAS_CLK_PERIOD_NS)

`endif

// ===== sas_sync.v
`timescale 1ns/1ps
// three-stage input synchroniser with agreement filter
module sas_sync #(
	parameter W = 8
) (
	input  wire         ref_clk_in,
	input  wire         rst_n_in,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg  [W-1:0] s1_r;
	reg  [W-1:0] s2_r;
	reg  [W-1:0] s3_r;
	reg  [W-1:0] out_r;
	wire [W-1:0] agree;

	// bits where stages two and three match
	assign agree = ~(s2_r ^ s3_r);

	// stage one is read only by stage two
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			s1_r  <= {W{1'b0}};
			s2_r  <= {W{1'b0}};
			s3_r  <= {W{1'b0}};
			out_r <= {W{1'b0}};
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// take a bit once stages two and three agree
			out_r <= (s3_r & agree) | (out_r & ~agree);
		end
	end

	assign sync_out = out_r;
endmodule

// ===== sas_tad_gen.v
`timescale 1ns/1ps
`include "sas_regs.vh"
// half bit-period tick generator for the conversion clock
module sas_tad_gen (
	input  wire       ref_clk_in,
	input  wire       rst_n_in,
	input  wire       run_in,
	input  wire [1:0] clk_sel_in,
	input  wire       sleep_in,
	input  wire       rc_level_in,
	output wire       half_tick_out
);
	reg  [4:0] cnt_r;
	reg        rc_prev_r;
	reg        tick_r;
	reg  [4:0] half_len;

	// half period length per divider setting
	always @*
	begin
		case (clk_sel_in)
			`SAS_CLK_DIV2:  half_len = `SAS_HALF_DIV2;
			`SAS_CLK_DIV8:  half_len = `SAS_HALF_DIV8;
			default:        half_len = `SAS_HALF_DIV32;
		endcase
	end

	// divider ticks, or both edges of the rc clock
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			cnt_r     <= 5'h00;
			rc_prev_r <= 1'b0;
			tick_r    <= 1'b0;
		end
		else if (!run_in)
		begin
			cnt_r     <= 5'h00;
			rc_prev_r <= rc_level_in;
			tick_r    <= 1'b0;
		end
		else if (clk_sel_in == `SAS_CLK_RC)
		begin
			tick_r    <= rc_level_in != rc_prev_r;
			rc_prev_r <= rc_level_in;
		end
		else if (sleep_in)
		begin
			tick_r <= 1'b0;
		end
		else if (cnt_r == half_len - 5'h01)
		begin
			cnt_r  <= 5'h00;
			tick_r <= 1'b1;
		end
		else
		begin
			cnt_r  <= cnt_r + 5'h01;
			tick_r <= 1'b0;
		end
	end

	assign half_tick_out = tick_r;
endmodule

// ===== sas_sequencer.v
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "sas_regs.vh"
module sas_sequencer (
	input  wire       ref_clk_in,
	input  wire       rst_n_in,
	input  wire [7:0] reg_addr_in,
	input  wire [7:0] reg_wdata_in,
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	output wire [7:0] reg_rdata_out,
	input  wire       cmp_in,
	input  wire       rc_osc_in,
	input  wire [5:0] port_pins_in,
	input  wire       sleep_in,
	input  wire [3:0] ccp_mode_in,
	input  wire       ccp_trigger_in,
	output wire       power_on_out,
	output wire [2:0] channel_out,
	output wire       vref_ext_out,
	output wire       hold_isolate_out,
	output wire [7:0] dac_code_out,
	output wire       conv_done_out,
	output wire [5:0] analog_mask_out,
	output wire [5:0] port_read_out
);
	localparam ST_IDLE = 1'b0;
	localparam ST_CONV = 1'b1;
	localparam [7:0] CTL_RST = `SAS_CTL_RESET;

	// control and configuration state
	reg        state_r;
	reg        state_nxt;
	reg        pwr_r;
	reg        go_r;
	reg        go_nxt;
	reg  [2:0] chan_r;
	reg  [1:0] clk_sel_r;
	reg  [2:0] pincfg_r;
	reg  [7:0] result_r;
	reg  [7:0] dac_r;
	reg  [7:0] dac_nxt;
	reg  [4:0] half_cnt_r;
	reg  [4:0] half_cnt_nxt;
	reg  [2:0] bit_idx_r;
	reg  [2:0] bit_idx_nxt;
	reg        isolate_r;
	reg        done_r;
	reg        done_nxt;
	reg        vref_ext_r;
	reg  [5:0] amask_r;
	reg  [5:0] port_rd_r;
	reg  [7:0] rdata_r;

	wire [7:0] sync_bits;
	wire       cmp_s;
	wire       rc_s;
	wire [5:0] pins_s;
	wire       half_tick;
	wire       wr_ctl;
	wire       wr_pin;
	wire       start_req;
	wire       abort_req;
	wire       pwr_wr_val;
	wire [4:0] half_inc;
	wire       pwr_keep;
	wire [6:0] pin_mode;

	// comparator, rc clock and port pins pass the three-stage filter
	sas_sync #(
		.W (8)
	) u_sync (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.async_in   ({port_pins_in, rc_osc_in, cmp_in}),
		.sync_out   (sync_bits)
	);

	assign cmp_s  = sync_bits[0];
	assign rc_s   = sync_bits[1];
	assign pins_s = sync_bits[7:2];

	// half period ticks, only while converting
	sas_tad_gen u_tad (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.run_in        (state_r == ST_CONV),
		.clk_sel_in    (clk_sel_r),
		.sleep_in      (sleep_in),
		.rc_level_in   (rc_s),
		.half_tick_out (half_tick)
	);

	// pin mode decode: {vref on pin 3, analog mask}
	function [6:0] pin_decode;
		input [2:0] code;
		begin
			case (code)
				3'h0:    pin_decode = 7'h2F;
				3'h1:    pin_decode = 7'h67;
				3'h2:    pin_decode = 7'h07;
				3'h3:    pin_decode = 7'h4F;
				3'h4:    pin_decode = 7'h0B;
				3'h5:    pin_decode = 7'h4B;
				default: pin_decode = 7'h00;
			endcase
		end
	endfunction

	// register port decode
	assign wr_ctl     = reg_wr_in && (reg_addr_in == `SAS_ADDR_CONTROL);
	assign wr_pin     = reg_wr_in && (reg_addr_in == `SAS_ADDR_PINCFG);
	assign pwr_wr_val = reg_wdata_in[`SAS_CTL_PWR];
	assign half_inc   = half_cnt_r + 5'h01;
	assign pin_mode   = pin_decode(pincfg_r);

	// a write that powers off never starts
	assign pwr_keep   = !wr_ctl || pwr_wr_val;

	assign start_req = pwr_r && pwr_keep &&
		((wr_ctl && reg_wdata_in[`SAS_CTL_GO]) ||
		 (ccp_trigger_in && (ccp_mode_in == `SAS_CCP_SPECIAL)));

	// software clearing power stops a conversion; clearing go does unless a special-event trigger comes in the same cycle
	assign abort_req = wr_ctl && (!reg_wdata_in[`SAS_CTL_GO] || !pwr_wr_val);

	// conversion sequencer next state
	always @*
	begin
		state_nxt    = state_r;
		go_nxt       = go_r;
		dac_nxt      = dac_r;
		half_cnt_nxt = half_cnt_r;
		bit_idx_nxt  = bit_idx_r;
		done_nxt     = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				if (start_req)
				begin
					state_nxt    = ST_CONV;
					go_nxt       = 1'b1;
					dac_nxt      = `SAS_SAR_START;
					half_cnt_nxt = 5'h00;
					bit_idx_nxt  = 3'h7;
				end
			end
			ST_CONV:
			begin
				if (abort_req && !start_req)
				begin
					state_nxt = ST_IDLE;
					go_nxt    = 1'b0;
				end
				else if (half_tick)
				begin
					half_cnt_nxt = half_inc;
					if (!half_inc[0] && half_inc <= `SAS_LAST_DECIDE)
					begin
						dac_nxt[bit_idx_r] = cmp_s;
						if (bit_idx_r != 3'h0)
							dac_nxt[bit_idx_r - 3'h1] = 1'b1;
						bit_idx_nxt = bit_idx_r - 3'h1;
					end
					// end after nine and half periods
					if (half_inc == `SAS_CONV_HALVES)
					begin
						done_nxt  = 1'b1;
						state_nxt = ST_IDLE;
						go_nxt    = 1'b0;
						// a start in the same cycle wins
						if (start_req)
						begin
							state_nxt    = ST_CONV;
							go_nxt       = 1'b1;
							dac_nxt      = `SAS_SAR_START;
							half_cnt_nxt = 5'h00;
							bit_idx_nxt  = 3'h7;
						end
					end
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
				go_nxt    = 1'b0;
			end
		endcase
	end

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			state_r    <= ST_IDLE;
			go_r       <= 1'b0;
			pwr_r      <= 1'b0;
			chan_r     <= CTL_RST[`SAS_CTL_CHAN_HI:`SAS_CTL_CHAN_LO];
			clk_sel_r  <= CTL_RST[`SAS_CTL_CLK_HI:`SAS_CTL_CLK_LO];
			pincfg_r   <= `SAS_PINCFG_RESET;
			dac_r      <= 8'h00;
			half_cnt_r <= 5'h00;
			bit_idx_r  <= 3'h7;
			isolate_r  <= 1'b0;
			done_r     <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			go_r       <= go_nxt;
			dac_r      <= dac_nxt;
			half_cnt_r <= half_cnt_nxt;
			bit_idx_r  <= bit_idx_nxt;
			done_r     <= done_nxt;
			isolate_r  <= state_nxt == ST_CONV;
			if (wr_ctl)
			begin
				pwr_r     <= pwr_wr_val;
				chan_r    <= reg_wdata_in[`SAS_CTL_CHAN_HI:`SAS_CTL_CHAN_LO];
				clk_sel_r <= reg_wdata_in[`SAS_CTL_CLK_HI:`SAS_CTL_CLK_LO];
			end
			if (wr_pin)
				pincfg_r <= reg_wdata_in[2:0];
		end
	end

	always @(posedge ref_clk_in)
	begin
		// load result, final code even on restart
		if (done_nxt)
			result_r <= dac_r;
	end

	// pin mode outputs and port read-back
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			vref_ext_r <= 1'b0;
			amask_r    <= 6'h00;
			port_rd_r  <= 6'h00;
		end
		else
		begin
			vref_ext_r <= pin_mode[6];
			amask_r    <= pin_mode[5:0];
			port_rd_r  <= pins_s & ~amask_r;
		end
	end

	// register read, data one cycle after strobe
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			rdata_r <= 8'h00;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				`SAS_ADDR_CONTROL: rdata_r <= {clk_sel_r, chan_r, go_r, 1'b0, pwr_r};
				`SAS_ADDR_PINCFG:  rdata_r <= {5'h00, pincfg_r};
				`SAS_ADDR_RESULT:  rdata_r <= result_r;
				default:           rdata_r <= 8'h00;
			endcase
		end
		else
			rdata_r <= 8'h00;
	end

	// outputs straight from registers
	assign reg_rdata_out    = rdata_r;
	assign power_on_out     = pwr_r;
	assign channel_out      = chan_r;
	assign vref_ext_out     = vref_ext_r;
	assign hold_isolate_out = isolate_r;
	assign dac_code_out     = dac_r;
	assign conv_done_out    = done_r;
	assign analog_mask_out  = amask_r;
	assign port_read_out    = port_rd_r;
endmodule

// ===== sas_sequencer_chk.sv
`timescale 1ns/1ps
// port watcher for the converter sequencer
module sas_sequencer_chk (
	input	wire		ref_clk_in,
	input	wire		rst_n_in,
	input	wire [7:0]	reg_addr_in,
	input	wire [7:0]	reg_wdata_in,
	input	wire		reg_wr_in,
	input	wire		reg_rd_in,
	input	wire [7:0]	reg_rdata_out,
	input	wire		cmp_in,
	input	wire		rc_osc_in,
	input	wire [5:0]	port_pins_in,
	input	wire		sleep_in,
	input	wire [3:0]	ccp_mode_in,
	input	wire		ccp_trigger_in,
	input	wire		power_on_out,
	input	wire [2:0]	channel_out,
	input	wire		vref_ext_out,
	input	wire		hold_isolate_out,
	input	wire [7:0]	dac_code_out,
	input	wire		conv_done_out,
	input	wire [5:0]	analog_mask_out,
	input	wire [5:0]	port_read_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// a write to the control register
	sequence s_ctl_wr;
		reg_wr_in && reg_addr_in == 8'h1F;
	endsequence
	a_start_code: assert property ($rose(hold_isolate_out) |-> dac_code_out == 8'h80)
		else $error("trial code not 0x80 at start");
	a_power_follow: assert property (s_ctl_wr |=> power_on_out == $past(reg_wdata_in[0]))
		else $error("power does not follow write");
	a_chan_follow: assert property (s_ctl_wr |=> channel_out == $past(reg_wdata_in[5:3]))
		else $error("channel does not follow write");
	a_bit1_zero: assert property (reg_rd_in && reg_addr_in == 8'h1F |=> !reg_rdata_out[1])
		else $error("control bit 1 reads one");
	a_off_idle: assert property (!power_on_out |-> !hold_isolate_out)
		else $error("converting while off");
	a_done_length: assert property ($rose(conv_done_out) |-> $past(hold_isolate_out, 19))
		else $error("conversion ended too soon");
	a_trig_start: assert property (ccp_trigger_in && ccp_mode_in == 4'hB && power_on_out
		&& !hold_isolate_out && !reg_wr_in |=> hold_isolate_out)
		else $error("trigger did not start");
	a_mask_read: assert property ($stable(analog_mask_out) [*2]
		|-> (port_read_out & analog_mask_out) == 6'h00)
		else $error("analog pin reads one");
endmodule

bind sas_sequencer sas_sequencer_chk u_chk (.*);

// ===== sas_analog_model.sv
`timescale 1ns/1ps
// held sample and comparator beside the sequencer
module sas_analog_model (
	input	wire		ref_clk_in,
	input	wire		hold_isolate_in,
	input	wire [7:0]	dac_code_in,
	input	wire [7:0]	level_in,
	output	wire		cmp_out
);
	logic [7:0] held_r;
	always @(posedge ref_clk_in)
	begin
		if (!hold_isolate_in)
			held_r <= level_in;
	end
	// compare held level with trial code
	assign cmp_out = held_r >= dac_code_in;
endmodule

// ===== sas_sequencer_test.sv
`timescale 1ns/1ps
// self-checking bench for the converter sequencer
module sas_sequencer_test;
	logic		ref_clk_in, rst_n_in, reg_wr_in, reg_rd_in, cmp_in, rc_osc_in, sleep_in;
	logic		ccp_trigger_in, power_on_out, vref_ext_out, hold_isolate_out, conv_done_out;
	logic [7:0]	reg_addr_in, reg_wdata_in, reg_rdata_out, dac_code_out, level, d, ctl;
	logic [5:0]	port_pins_in, analog_mask_out, port_read_out;
	logic [3:0]	ccp_mode_in;
	logic [2:0]	channel_out;
	int		n_mismatch, n_tests, cnt, hh;
	logic [5:0]	masks [8] = '{6'h2F, 6'h27, 6'h07, 6'h0F, 6'h0B, 6'h0B, 6'h00, 6'h00};
	sas_sequencer u_dut (.*);
	sas_analog_model u_ana (.ref_clk_in(ref_clk_in), .hold_isolate_in(hold_isolate_out),
		.dac_code_in(dac_code_out), .level_in(level), .cmp_out(cmp_in));
	// reference clock and rc oscillator
	initial
	begin
		ref_clk_in = 0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	initial
	begin
		rc_osc_in = 0;
		forever #170 rc_osc_in = ~rc_osc_in;
	end
	task chk(input logic [7:0] s, e);
	begin
		n_tests++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t saw %h want %h", $time, s, e);
		end
	end
	endtask
	task wr(input logic [7:0] a, v);
	begin
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1;
		@(posedge ref_clk_in);
		reg_wr_in <= 0;
		#1;
	end
	endtask
	task rd(input logic [7:0] a);
	begin
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1;
		@(posedge ref_clk_in);
		reg_rd_in <= 0;
		#1 d = reg_rdata_out;
	end
	endtask
	// bounded wait for the completion pulse
	// completion seen as flag set pulse
	task wait_done(input int lim);
	begin
		#1 cnt = 0;
		while (conv_done_out !== 1 && cnt < lim)
		begin
			@(posedge ref_clk_in);
			#1 cnt++;
		end
	end
	endtask
	task tally_and_finish;
	begin
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// watchdog
	initial
	begin
		#500000;
		n_mismatch++;
		tally_and_finish;
	end
	// main sequence
	initial
	begin
		{reg_wr_in, reg_rd_in, sleep_in, ccp_trigger_in} = 0;
		{reg_addr_in, reg_wdata_in, ccp_mode_in, level} = 0;
		port_pins_in = 6'h3F;
		rst_n_in = 0;
		repeat (4) @(posedge ref_clk_in);
		rst_n_in <= 1;
		rd(8'h1F);
		chk(d, 8'h00);
		rd(8'h40);
		chk(d, 8'h00);
		wr(8'h1F, 8'h06);
		rd(8'h1F);
		chk(d, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h9F, i[7:0]);
			repeat (6) @(posedge ref_clk_in);
			rd(8'h9F);
			chk(d, i[7:0]);
			chk(analog_mask_out, masks[i]);
			chk(port_read_out, 6'h3F ^ masks[i]);
			chk(vref_ext_out, i == 1 || i == 3 || i == 5);
		end
		$display("test pins done");
		for (int cs = 0; cs < 4; cs++)
		begin
			level <= 8'h3C + 8'(cs * 41);
			sleep_in <= (cs == 3);
			ctl = {cs[1:0], 3'(cs + 1), 3'b001};
			wr(8'h1F, ctl);
			chk(channel_out, ctl[5:3]);
			repeat (600) @(posedge ref_clk_in);
			wr(8'h1F, ctl | 8'h04);
			rd(8'h1F);
			chk(d, ctl | 8'h04);
			wait_done(2000);
			hh = (cs == 0) ? 1 : (cs == 1) ? 4 : 16;
			chk(cnt < 2000, 1);
			if (cs < 3)
				chk(cnt >= 19 * hh - 3 && cnt <= 19 * hh + 3, 1);
			@(posedge ref_clk_in);
			#1 chk(hold_isolate_out, 0);
			rd(8'h1E);
			if (cs > 0)
				chk(d, level);
			rd(8'h1F);
			chk(d, ctl);
			repeat (40) @(posedge ref_clk_in);
		end
		sleep_in <= 0;
		$display("test convert done");
		wr(8'h1F, 8'h85);
		repeat (50) @(posedge ref_clk_in);
		wr(8'h1F, 8'h80);
		wait_done(400);
		chk(cnt == 400, 1);
		wr(8'h1F, 8'h85);
		rd(8'h1F);
		chk(d, 8'h81);
		wr(8'h1F, 8'h85);
		repeat (50) @(posedge ref_clk_in);
		rst_n_in <= 0;
		repeat (4) @(posedge ref_clk_in);
		rst_n_in <= 1;
		rd(8'h1F);
		chk(d, 8'h00);
		chk(power_on_out, 0);
		rd(8'h1E);
		chk(d, level);
		$display("test abort done");
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h1F, {7'h40, i != 0});
			@(posedge ref_clk_in);
			ccp_mode_in <= (i == 1) ? 4'hA : 4'hB;
			ccp_trigger_in <= 1;
			@(posedge ref_clk_in);
			ccp_trigger_in <= 0;
			wait_done(400);
			chk(cnt < 400, i == 2);
		end
		$display("test trigger done");
		tally_and_finish;
	end
endmodule
